// ===== logic/reset_timeout_sequencer.sv
`timescale 1ns/1ps
module reset_timeout_sequencer #(
  parameter int PWRUP_CYCLES = rst_seq_pkg::PWRUP_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // supply and pins
  input  wire logic        supply_ok,
  input  wire logic        master_clear_n,
  input  wire logic        osc_in_pin,
  output logic             osc_out_pin_o,
  output logic             osc_out_pin_oe,
  // configuration
  input  wire logic [2:0]  osc_mode,
  input  wire logic        powerup_delay_enable_n,
  // core events
  input  wire logic        in_sleep,
  input  wire logic        watchdog_timeout,
  input  wire logic        wake_irq,
  input  wire logic        wake_conv_done,
  input  wire logic        global_irq_enable,
  input  wire logic [12:0] pc_now,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata,
  // core outputs
  output logic             core_reset,
  output logic             pc_load,
  output logic [12:0]      pc_value,
  output logic             watchdog_expired_flag_n,
  output logic             sleep_entered_flag_n,
  output logic             status_top_clear,
  output logic             periph_conv_set,
  output logic             conv_go_clear
);
  // ------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------
  localparam int FW = $clog2(rst_seq_pkg::FILT_CYCLES + 1);
  logic          master_clear_n_filt_reg;
  logic [FW-1:0] filt_cnt_reg;
  logic          osc_q1_reg;
  logic          osc_q2_reg;
  logic          osc_q3_reg;
  logic          supply_reg;
  logic          por_pulse;

  // short pulses on master clear are ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      master_clear_n_filt_reg <= 1'b1;
      filt_cnt_reg  <= '0;
    end else if (master_clear_n == master_clear_n_filt_reg) begin
      filt_cnt_reg <= '0;
    end else if (filt_cnt_reg == FW'(rst_seq_pkg::FILT_CYCLES - 1)) begin
      master_clear_n_filt_reg <= master_clear_n;
      filt_cnt_reg  <= '0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + FW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_q1_reg <= 1'b0;
      osc_q2_reg <= 1'b0;
      osc_q3_reg <= 1'b0;
      supply_reg <= 1'b0;
    end else begin
      osc_q1_reg <= osc_in_pin;
      osc_q2_reg <= osc_q1_reg;
      osc_q3_reg <= osc_q2_reg;
      supply_reg <= supply_ok;
    end
  end
  assign por_pulse = supply_ok && !supply_reg;

  // ------------------------------------------------------------
  // rc tick and timers
  // ------------------------------------------------------------
  localparam int RW = $clog2(rst_seq_pkg::RC_DIV);
  logic [RW-1:0] rc_div_reg;
  logic          rc_tick;
  logic          osc_edge;
  seq_timer_if   powerup_timer_if ();
  seq_timer_if   ost_if ();

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rc_div_reg <= '0;
    else if (rc_div_reg == RW'(rst_seq_pkg::RC_DIV - 1)) rc_div_reg <= '0;
    else rc_div_reg <= rc_div_reg + RW'(1);
  end
  assign rc_tick  = (rc_div_reg == RW'(rst_seq_pkg::RC_DIV - 1));
  assign osc_edge = osc_q2_reg && !osc_q3_reg;
  // power-up timer runs only on its own rc tick
  assign powerup_timer_if.tick = rc_tick;
  assign ost_if.tick  = osc_edge;

  seq_counter #(.COUNT(PWRUP_CYCLES / rst_seq_pkg::RC_DIV)) u_powerup_timer (
    .clk  (clk),
    .rstn (rstn),
    .tif  (powerup_timer_if.timer)
  );
  seq_counter #(.COUNT(rst_seq_pkg::OST_CYCLES)) u_ost (
    .clk  (clk),
    .rstn (rstn),
    .tif  (ost_if.timer)
  );

  // ------------------------------------------------------------
  // time-out sequence
  // ------------------------------------------------------------
  rst_seq_pkg::seq_state_t state_reg;
  rst_seq_pkg::seq_state_t state_next;
  logic powerup_timer_start;
  logic ost_start;
  logic wake_any;
  logic wake_ost_reg;

  assign wake_any = in_sleep && (watchdog_timeout || wake_irq);

  always_comb begin
    state_next = state_reg;
    powerup_timer_start = 1'b0;
    ost_start  = 1'b0;
    case (state_reg)
      rst_seq_pkg::ST_POR: begin
        if (supply_ok) begin
          if (!powerup_delay_enable_n) begin
            state_next = rst_seq_pkg::ST_POWERUP_TIMER;
            powerup_timer_start = 1'b1;
          end else if (rst_seq_pkg::is_crystal(osc_mode)) begin
            state_next = rst_seq_pkg::ST_OST;
            ost_start  = 1'b1;
          end else begin
            state_next = rst_seq_pkg::ST_RUN;
          end
        end
      end
      rst_seq_pkg::ST_POWERUP_TIMER: begin
        if (powerup_timer_if.done) begin
          if (rst_seq_pkg::is_crystal(osc_mode)) begin
            state_next = rst_seq_pkg::ST_OST;
            ost_start  = 1'b1;
          end else begin
            state_next = rst_seq_pkg::ST_RUN;
          end
        end
      end
      rst_seq_pkg::ST_OST: begin
        if (ost_if.done) state_next = rst_seq_pkg::ST_RUN;
      end
      rst_seq_pkg::ST_RUN: begin
        // crystal wake waits for the start-up count again
        if (wake_any && rst_seq_pkg::is_crystal(osc_mode)) begin
          state_next = rst_seq_pkg::ST_OST;
          ost_start  = 1'b1;
        end
      end
      default: state_next = rst_seq_pkg::ST_POR;
    endcase
    if (!supply_ok) state_next = rst_seq_pkg::ST_POR;
  end
  assign powerup_timer_if.start = powerup_timer_start;
  assign ost_if.start  = ost_start;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_reg <= rst_seq_pkg::ST_POR;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wake_ost_reg <= 1'b0;
    else if (ost_start && state_reg == rst_seq_pkg::ST_RUN) wake_ost_reg <= 1'b1;
    else if (state_reg != rst_seq_pkg::ST_OST) wake_ost_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // reset output and pins
  // ------------------------------------------------------------
  logic seq_hold;
  assign seq_hold = (state_reg != rst_seq_pkg::ST_RUN) || wake_ost_reg;

  // delays run independent of master clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) core_reset <= 1'b1;
    else core_reset <= seq_hold || !master_clear_n_filt_reg || !supply_ok;
  end

  // watchdog never drives the pin; only filtered master clear acts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_out_pin_o  <= 1'b0;
      osc_out_pin_oe <= 1'b0;
    end else begin
      osc_out_pin_o  <= 1'b0;
      osc_out_pin_oe <= !master_clear_n_filt_reg && rst_seq_pkg::is_clkout(osc_mode);
    end
  end

  // ------------------------------------------------------------
  // reset cause, flags and pc
  // ------------------------------------------------------------
  logic master_clear_n_fall;
  logic master_clear_n_prev_reg;
  logic por_done_reg;
  logic wdt_run;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) master_clear_n_prev_reg <= 1'b1;
    else master_clear_n_prev_reg <= master_clear_n_filt_reg;
  end
  assign master_clear_n_fall = master_clear_n_prev_reg && !master_clear_n_filt_reg;
  assign wdt_run   = watchdog_timeout && !in_sleep && !core_reset;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) por_done_reg <= 1'b0;
    else if (state_reg == rst_seq_pkg::ST_POR) por_done_reg <= 1'b0;
    else por_done_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_expired_flag_n <= 1'b1;
      sleep_entered_flag_n    <= 1'b1;
      status_top_clear        <= 1'b0;
      pc_load                 <= 1'b0;
      pc_value                <= rst_seq_pkg::RESET_VECTOR;
      periph_conv_set         <= 1'b0;
      conv_go_clear           <= 1'b0;
    end else begin
      status_top_clear <= 1'b0;
      pc_load          <= 1'b0;
      periph_conv_set  <= 1'b0;
      conv_go_clear    <= 1'b0;
      if (!por_done_reg) begin
        watchdog_expired_flag_n <= 1'b1;
        sleep_entered_flag_n    <= 1'b1;
        status_top_clear        <= 1'b1;
        pc_load                 <= 1'b1;
        pc_value                <= rst_seq_pkg::RESET_VECTOR;
      end else if (master_clear_n_fall && in_sleep) begin
        watchdog_expired_flag_n <= 1'b1;
        sleep_entered_flag_n    <= 1'b0;
        status_top_clear        <= 1'b1;
        pc_load                 <= 1'b1;
        pc_value                <= rst_seq_pkg::RESET_VECTOR;
      end else if (master_clear_n_fall) begin
        status_top_clear <= 1'b1;
        pc_load          <= 1'b1;
        pc_value         <= rst_seq_pkg::RESET_VECTOR;
      end else if (wdt_run) begin
        watchdog_expired_flag_n <= 1'b0;
        status_top_clear        <= 1'b1;
        pc_load                 <= 1'b1;
        pc_value                <= rst_seq_pkg::RESET_VECTOR;
      end else if (in_sleep && watchdog_timeout) begin
        watchdog_expired_flag_n <= 1'b0;
        sleep_entered_flag_n    <= 1'b0;
        pc_load                 <= 1'b1;
        pc_value                <= pc_now + 13'h0001;
      end else if (in_sleep && wake_irq) begin
        watchdog_expired_flag_n <= 1'b1;
        sleep_entered_flag_n    <= 1'b0;
        pc_load                 <= 1'b1;
        pc_value                <= global_irq_enable ? rst_seq_pkg::IRQ_VECTOR : pc_now + 13'h0001;
        periph_conv_set         <= wake_conv_done;
        conv_go_clear           <= wake_conv_done;
      end
    end
  end

  // ------------------------------------------------------------
  // power control register
  // ------------------------------------------------------------
  logic por_flag_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) por_flag_reg <= rst_seq_pkg::PWR_CTRL_RST[rst_seq_pkg::POR_FLAG_BIT];
    else if (state_reg == rst_seq_pkg::ST_POR) por_flag_reg <= 1'b0;
    else if (wr && addr == rst_seq_pkg::PWR_CTRL_OFS) por_flag_reg <= wdata[rst_seq_pkg::POR_FLAG_BIT];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata <= 8'h00;
    else if (rd && addr == rst_seq_pkg::PWR_CTRL_OFS) rdata <= {6'h00, por_flag_reg, 1'b0};
    else rdata <= 8'h00;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_PIN_LOW: assert property (@(posedge clk) disable iff (!rstn)
    osc_out_pin_oe |-> !osc_out_pin_o) else $error("osc out driven high in reset");
  AST_POR_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !supply_ok |=> core_reset) else $error("reset released without supply");
  AST_POWERUP_TIMER_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == rst_seq_pkg::ST_POWERUP_TIMER |=> core_reset) else $error("reset released during power-up timer");
  AST_NO_DELAY: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == rst_seq_pkg::ST_POR && supply_ok && powerup_delay_enable_n &&
     !rst_seq_pkg::is_crystal(osc_mode)) |=> state_reg == rst_seq_pkg::ST_RUN)
    else $error("rc mode delay not skipped");
  AST_POWERUP_TIMER_ENABLE: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == rst_seq_pkg::ST_POR && supply_ok && !powerup_delay_enable_n) |=>
    state_reg == rst_seq_pkg::ST_POWERUP_TIMER) else $error("power-up timer not started");
  AST_OST_MODE: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == rst_seq_pkg::ST_OST |-> rst_seq_pkg::is_crystal(osc_mode))
    else $error("start-up count in rc mode");
  AST_POR_FLAG: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == rst_seq_pkg::ST_POR |=> !por_flag_reg) else $error("power-on flag not cleared");
  AST_WDT_WAKE: assert property (@(posedge clk) disable iff (!rstn)
    (por_done_reg && !master_clear_n_fall && in_sleep && watchdog_timeout) |=>
    (pc_load && pc_value == $past(pc_now) + 13'h0001 && !watchdog_expired_flag_n && !sleep_entered_flag_n))
    else $error("watchdog wake wrong");
  AST_IRQ_VEC: assert property (@(posedge clk) disable iff (!rstn)
    (por_done_reg && !master_clear_n_fall && in_sleep && !watchdog_timeout && wake_irq && global_irq_enable) |=>
    pc_value == rst_seq_pkg::IRQ_VECTOR) else $error("irq vector not loaded");
  AST_POR_START: assert property (@(posedge clk) disable iff (!rstn)
    (por_pulse && state_reg == rst_seq_pkg::ST_POR && !powerup_delay_enable_n) |=>
    state_reg == rst_seq_pkg::ST_POWERUP_TIMER) else $error("power-up timer not started from power-on");
  AST_OST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == rst_seq_pkg::ST_OST |=> core_reset)
    else $error("reset released during start-up count");
  AST_POWERUP_TIMER_RUNS: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == rst_seq_pkg::ST_POWERUP_TIMER && !powerup_timer_if.done && supply_ok) |=>
    state_reg == rst_seq_pkg::ST_POWERUP_TIMER) else $error("power-up timer cut short");
  AST_MASTER_CLEAR_N_FILTER: assert property (@(posedge clk) disable iff (!rstn)
    (master_clear_n && master_clear_n_filt_reg ##1 !master_clear_n [*2] ##1 master_clear_n) |=> master_clear_n_filt_reg)
    else $error("short master clear pulse not filtered");
  AST_WDT_RUN: assert property (@(posedge clk) disable iff (!rstn)
    (por_done_reg && !master_clear_n_fall && wdt_run) |=>
    (pc_load && pc_value == rst_seq_pkg::RESET_VECTOR && !watchdog_expired_flag_n))
    else $error("watchdog reset wrong");
  AST_CONV_WAKE: assert property (@(posedge clk) disable iff (!rstn)
    (por_done_reg && !master_clear_n_fall && in_sleep && !watchdog_timeout && wake_irq) |=>
    (periph_conv_set == $past(wake_conv_done) && conv_go_clear == $past(wake_conv_done)))
    else $error("conversion wake flags wrong");
  AST_MASTER_CLEAR_N_SLEEP: assert property (@(posedge clk) disable iff (!rstn)
    (por_done_reg && master_clear_n_fall && in_sleep) |=> (watchdog_expired_flag_n && !sleep_entered_flag_n))
    else $error("master clear in sleep flags wrong");
endmodule // reset_timeout_sequencer

// ===== logic/rst_seq_pkg.sv
// How it works
// - while master clear is low, osc output pin drives low in clock-out mode, else floats.
// - power-on detector holds the whole chip in reset until supply is good.
// - power-up timer gives 72 ms from power-on detection, at power-up only.
// - power-up timer runs on its own rc tick; reset held while it runs.
// - power-up delay applied when its enable bit is 0, skipped when 1.
// - oscillator start-up counts 1024 osc input cycles after the power-up delay.
// - start-up count only in the three crystal modes, on power-on or wake.
// - sequence is power-on, then power-up timer, then oscillator start-up count.
// - rc modes with power-up timer disabled leave reset without any delay.
// - delays run regardless of master clear; release after them starts at once.
// - power-on flag, bit 1 at 8Eh, cleared by power-on reset, and written by the core at 8Eh.
// - power-on reset sets both status flags, pc 000h, status 0001 1xxx.
// - master clear in run gives pc 000h, clears top three status bits.
// - master clear in sleep or irq wake sets timeout flag, clears power-down.
// - watchdog reset in run gives pc 000h and clears the timeout flag.
// - watchdog wake continues at pc+1, clears both flags, keeps the rest.
// - irq wake with global enable set loads pc with vector 0004h.
// - conversion-done wake makes peripheral flag bit 6 read 1.
// - conversion-done wake makes converter control bit 3 read 0.
// - master clear input filters out short pulses.
// - watchdog reset acts internally and never pulls the master clear pin.
package rst_seq_pkg;
  localparam logic [7:0]  PWR_CTRL_OFS    = 8'h8e;
  localparam int          POR_FLAG_BIT    = 1;
  localparam logic [7:0]  PWR_CTRL_RST    = 8'h00;
  localparam int          PERIPH_CONV_BIT = 6;
  localparam int          CONV_GO_BIT     = 3;
  localparam int          STAT_TO_BIT     = 4;
  localparam int          STAT_PD_BIT     = 3;
  localparam logic [12:0] RESET_VECTOR    = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
  localparam int          CLK_MHZ         = 125;
  localparam int          PWRUP_MS        = 72;
  localparam int          PWRUP_CYCLES    = PWRUP_MS * CLK_MHZ * 1000;
  localparam int          RC_DIV          = 125;
  localparam int          OST_CYCLES      = 1024;
  localparam int          FILT_CYCLES     = 4;
  localparam logic [2:0]  MODE_LP         = 3'h0;
  localparam logic [2:0]  MODE_XT         = 3'h1;
  localparam logic [2:0]  MODE_HS         = 3'h2;
  localparam logic [2:0]  MODE_INTERNAL_RC_MODE_IO   = 3'h4;
  localparam logic [2:0]  MODE_INTERNAL_RC_MODE_CK   = 3'h5;
  localparam logic [2:0]  MODE_EXTERNAL_RC_MODE_IO   = 3'h6;
  localparam logic [2:0]  MODE_EXTERNAL_RC_MODE_CK   = 3'h7;
  typedef enum logic [3:0] {
    ST_POR  = 4'b0001,
    ST_POWERUP_TIMER = 4'b0010,
    ST_OST  = 4'b0100,
    ST_RUN  = 4'b1000
  } seq_state_t;
  function automatic logic is_crystal(input logic [2:0] m);
    return (m == MODE_LP) || (m == MODE_XT) || (m == MODE_HS);
  endfunction
  function automatic logic is_clkout(input logic [2:0] m);
    return (m == MODE_INTERNAL_RC_MODE_CK) || (m == MODE_EXTERNAL_RC_MODE_CK);
  endfunction
endpackage

// ===== logic/seq_timer_if.sv
`timescale 1ns/1ps
interface seq_timer_if;
  logic start;
  logic tick;
  logic done;
  modport ctrl  (output start, output tick, input done);
  modport timer (input start, input tick, output done);
endinterface

// ===== logic/seq_counter.sv
`timescale 1ns/1ps
// counts ticks after start; done is a level until next start
module seq_counter #(
  parameter int COUNT = 16
) (
  input wire logic clk,
  input wire logic rstn,
  seq_timer_if.timer tif
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_reg;
  logic         run_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (tif.start) begin
      cnt_reg <= '0;
      run_reg <= 1'b1;
    end else if (run_reg && tif.tick) begin
      cnt_reg <= cnt_reg + W'(1);
      if (cnt_reg == W'(COUNT - 1)) run_reg <= 1'b0;
    end
  end
  assign tif.done = !run_reg && (cnt_reg == W'(COUNT));
endmodule // seq_counter

// ===== dv/supply_master_clear_n_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// supply ramp, master clear pin, crystal
// ----------------------------------------
module supply_master_clear_n_model (
  // clock
  input  wire logic clk,
  // far-side pins
  output logic      supply_ok,
  output logic      master_clear_n,
  output logic      osc_in_pin
);
  logic master_clear_n_pull_low;

  // pin has a pull-up: released reads high
  assign master_clear_n = master_clear_n_pull_low ? 1'b0 : 1'b1;

  initial begin
    supply_ok     = 1'b0;
    master_clear_n_pull_low = 1'b0;
  end

  // crystal swings only while powered; edges kept off the clock edges
  initial begin
    osc_in_pin = 1'b0;
    #2;
    forever #12 osc_in_pin = supply_ok ? ~osc_in_pin : 1'b0;
  end

  task automatic set_supply(input logic on);
    @(posedge clk);
    supply_ok <= on;
  endtask

  task automatic hold_master_clear_n(input logic low);
    @(posedge clk);
    master_clear_n_pull_low <= low;
  endtask

  task automatic press_master_clear_n(input int cycles);
    @(posedge clk);
    master_clear_n_pull_low <= 1'b1;
    repeat (cycles) @(posedge clk);
    master_clear_n_pull_low <= 1'b0;
  endtask
endmodule // supply_master_clear_n_model

// ===== dv/reset_timeout_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ----------------------------------------
// signals
// ----------------------------------------
module reset_timeout_sequencer_tb;
  localparam int         PWRUP = 1250;
  localparam int         OSC_STARTUP_TIMER   = 3072;
  localparam logic [7:0] PCR   = rst_seq_pkg::PWR_CTRL_OFS;
  logic        clk, rstn, supply_ok, master_clear_n, osc_in_pin, osc_out_pin_o, osc_out_pin_oe;
  logic [2:0]  osc_mode;
  logic        powerup_delay_enable_n, in_sleep, watchdog_timeout, wake_irq, wake_conv_done, global_irq_enable;
  logic [12:0] pc_now, pc_value, exp_pc, r13;
  logic [7:0]  addr, wdata, rdata, exp_rd, rnd, ra;
  logic        wr, rd, rd_d, core_reset, pc_load, watchdog_expired_flag_n, sleep_entered_flag_n;
  logic        status_top_clear, periph_conv_set, conv_go_clear;
  logic [3:0]  seen;
  logic [12:0] pc_q[$];
  logic [7:0]  rd_q[$];
  int          miscompares, n_compared, n;

  reset_timeout_sequencer #(.PWRUP_CYCLES(PWRUP)) dut (
    .clk(clk), .rstn(rstn), .supply_ok(supply_ok), .master_clear_n(master_clear_n), .osc_in_pin(osc_in_pin),
    .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe(osc_out_pin_oe), .osc_mode(osc_mode),
    .powerup_delay_enable_n(powerup_delay_enable_n), .in_sleep(in_sleep), .watchdog_timeout(watchdog_timeout),
    .wake_irq(wake_irq), .wake_conv_done(wake_conv_done), .global_irq_enable(global_irq_enable),
    .pc_now(pc_now), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_reset(core_reset),
    .pc_load(pc_load), .pc_value(pc_value), .watchdog_expired_flag_n(watchdog_expired_flag_n),
    .sleep_entered_flag_n(sleep_entered_flag_n), .status_top_clear(status_top_clear),
    .periph_conv_set(periph_conv_set), .conv_go_clear(conv_go_clear));
  supply_master_clear_n_model pm (.clk(clk), .supply_ok(supply_ok), .master_clear_n(master_clear_n), .osc_in_pin(osc_in_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      exp_rd = rd_q.pop_front();
      `CHK(rdata, exp_rd)
    end
    if (pc_load && pc_q.size() > 0) begin
      exp_pc = pc_q.pop_front();
      `CHK(pc_value, exp_pc)
    end
    if (status_top_clear) seen[0] <= 1'b1;
    if (periph_conv_set) seen[1] <= 1'b1;
    if (conv_go_clear) seen[2] <= 1'b1;
    if (core_reset) seen[3] <= 1'b1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    if (pc_q.size() != 0) miscompares++;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic fail_wait();
    miscompares++;
    $display("Error t=%0t wait bound used up got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  endtask

  task automatic wait_core(input logic v, input int max, output int cnt);
    cnt = 0;
    while (core_reset !== v) begin
      @(negedge clk);
      cnt++;
      if (cnt > max) fail_wait();
    end
  endtask

  task automatic wait_pcq(input int max);
    int cnt = 0;
    while (pc_q.size() != 0) begin
      @(negedge clk);
      cnt++;
      if (cnt > max) fail_wait();
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    if (r) rd_q.push_back(e);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask

  task automatic chk_flags(input logic to_n, input logic pd_n);
    @(negedge clk);
    `CHK(watchdog_expired_flag_n, to_n)
    `CHK(sleep_entered_flag_n, pd_n)
  endtask

  task automatic power_up(input logic [2:0] m, input logic pden, input logic hold, input int lo, input int hi);
    int cnt;
    @(posedge clk);
    rstn <= 1'b0;
    osc_mode <= m;
    powerup_delay_enable_n <= pden;
    pm.set_supply(1'b0);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    pc_q.push_back(rst_seq_pkg::RESET_VECTOR);
    pm.hold_master_clear_n(hold);
    repeat (3) @(negedge clk);
    `CHK(core_reset, 1'b1)
    pm.set_supply(1'b1);
    if (hold) begin
      repeat (hi) @(negedge clk);
      `CHK(core_reset, 1'b1)
      pm.hold_master_clear_n(1'b0);
      wait_core(1'b0, 8, cnt);
    end else begin
      wait_core(1'b0, hi, cnt);
      `CHK(cnt >= lo, 1'b1)
    end
    wait_pcq(10);
    chk_flags(1'b1, 1'b1);
    bus(1'b0, 1'b1, PCR, 8'h00, rst_seq_pkg::PWR_CTRL_RST);
    bus(1'b0, 1'b0, PCR, 8'h00, 8'h00);
  endtask

  task automatic master_clear_n_reset(input logic slp, input logic [2:0] m, input logic oe);
    int cnt;
    pc_q.push_back(rst_seq_pkg::RESET_VECTOR);
    seen = '0;
    @(posedge clk);
    in_sleep <= slp;
    osc_mode <= m;
    pm.hold_master_clear_n(1'b1);
    repeat (10) @(negedge clk);
    `CHK(osc_out_pin_oe, oe)
    `CHK(osc_out_pin_o, 1'b0)
    `CHK(core_reset, 1'b1)
    pm.hold_master_clear_n(1'b0);
    wait_core(1'b0, 20, cnt);
    wait_pcq(10);
    @(posedge clk);
    in_sleep <= 1'b0;
  endtask

  // ev is {watchdog, irq, conversion, global enable}
  task automatic wake(input logic slp, input logic [3:0] ev, input logic [12:0] p, input logic [12:0] e);
    pc_q.push_back(e);
    seen = '0;
    @(posedge clk);
    in_sleep <= slp;
    pc_now <= p;
    @(posedge clk);
    {watchdog_timeout, wake_irq, wake_conv_done, global_irq_enable} <= ev;
    @(posedge clk);
    {watchdog_timeout, wake_irq, wake_conv_done} <= 3'b000;
    wait_pcq(OSC_STARTUP_TIMER + 200);
    @(posedge clk);
    in_sleep <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    osc_mode = rst_seq_pkg::MODE_XT;
    {powerup_delay_enable_n, in_sleep, watchdog_timeout, wake_irq, wake_conv_done, global_irq_enable} = '0;
    {pc_now, addr, wdata, wr, rd, rd_d, seen} = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h39db_7e83));
    repeat (10) @(posedge clk);
    power_up(rst_seq_pkg::MODE_XT, 1'b0, 1'b0, PWRUP - 130 + OSC_STARTUP_TIMER, PWRUP + OSC_STARTUP_TIMER + 80);
    rnd = 8'($urandom());
    r13 = 13'($urandom_range(0, 8190));
    ra = 8'($urandom_range(0, 141));
    bus(1'b1, 1'b0, PCR, rnd, 8'h00);
    bus(1'b0, 1'b1, PCR, 8'h00, rnd & 8'h02);
    bus(1'b0, 1'b1, ra, 8'h00, 8'h00);
    bus(1'b1, 1'b0, PCR, 8'h02, 8'h00);
    bus(1'b0, 1'b0, PCR, 8'h00, 8'h00);
    master_clear_n_reset(1'b0, rst_seq_pkg::MODE_INTERNAL_RC_MODE_CK, 1'b1);
    chk_flags(1'b1, 1'b1);
    `CHK(seen[0], 1'b1)
    seen = '0;
    pm.press_master_clear_n(2);
    repeat (12) @(negedge clk);
    `CHK(core_reset, 1'b0)
    `CHK(seen[0], 1'b0)
    wake(1'b0, {2'b10, rnd[1:0]}, r13, rst_seq_pkg::RESET_VECTOR);
    chk_flags(1'b0, 1'b1);
    master_clear_n_reset(1'b0, rst_seq_pkg::MODE_EXTERNAL_RC_MODE_IO, 1'b0);
    chk_flags(1'b0, 1'b1);
    master_clear_n_reset(1'b1, rst_seq_pkg::MODE_EXTERNAL_RC_MODE_CK, 1'b1);
    chk_flags(1'b1, 1'b0);
    wake(1'b1, {2'b10, rnd[1:0]}, r13, 13'(r13 + 13'h0001));
    chk_flags(1'b0, 1'b0);
    wake(1'b1, 4'b0101, r13, rst_seq_pkg::IRQ_VECTOR);
    chk_flags(1'b1, 1'b0);
    wake(1'b1, 4'b0110, r13, 13'(r13 + 13'h0001));
    `CHK(seen[2:1], 2'b11)
    bus(1'b0, 1'b1, PCR, 8'h00, 8'h02);
    bus(1'b0, 1'b0, PCR, 8'h00, 8'h00);
    @(posedge clk);
    osc_mode <= rst_seq_pkg::MODE_XT;
    wake(1'b1, {2'b10, rnd[3:2]}, r13, 13'(r13 + 13'h0001));
    @(negedge clk);
    `CHK(seen[3], 1'b1)
    wait_core(1'b0, OSC_STARTUP_TIMER + 100, n);
    power_up(rst_seq_pkg::MODE_EXTERNAL_RC_MODE_IO, 1'b1, 1'b0, 0, 12);
    power_up(rst_seq_pkg::MODE_INTERNAL_RC_MODE_IO, 1'b0, 1'b0, PWRUP - 130, PWRUP + 80);
    power_up(rst_seq_pkg::MODE_LP, 1'b1, 1'b0, OSC_STARTUP_TIMER - 20, OSC_STARTUP_TIMER + 80);
    power_up(rst_seq_pkg::MODE_HS, 1'b0, 1'b1, 0, PWRUP + OSC_STARTUP_TIMER + 80);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule // reset_timeout_sequencer_tb
